/* mpba_pkg.sv */
// Constants and types for the multiprocessor bus arbitration block
// Summary of operation
// - Grant shows DMA starts next cycle
// - Only bus master drives DMA grants
// - Drive own request line, monitor others
// - Processor number selects own request line
// - Bus owner flag high only while master
// - Number 000 holds bus owner flag high
// - Priority select high rotating, low fixed
// - Priority access preempts master's background DMA
// - Host request beats all; release, then grant
package mpba_pkg;

  localparam int unsigned PROC_COUNT = 6;
  localparam int unsigned ID_WIDTH   = 3;

  localparam logic [ID_WIDTH-1:0] ID_NONE       = 3'h0;
  localparam logic [ID_WIDTH-1:0] ID_SINGLE     = 3'h0;
  localparam logic [ID_WIDTH-1:0] ID_FIRST      = 3'h1;
  localparam logic [ID_WIDTH-1:0] ID_LAST       = 3'h6;
  localparam logic [ID_WIDTH-1:0] ID_RESET_LAST = 3'h6;

  // Host grant floats for one input clock cycle before it is driven
  localparam int unsigned HOST_FLOAT_CYCLES = 1;

  typedef enum logic [1:0] {
    MPBA_HOST_IDLE    = 2'h0,
    MPBA_HOST_RELEASE = 2'h1,
    MPBA_HOST_GRANT   = 2'h3
  } mpba_host_state_type;

  typedef struct packed {
    logic [ID_WIDTH-1:0] owner;
    logic [ID_WIDTH-1:0] last_owner;
    mpba_host_state_type host_state;
    logic                dma_grant_first;
    logic                dma_grant_second;
    logic                dma_start_first;
    logic                dma_start_second;
    logic                owner_flag;
  } mpba_state_type;

  localparam mpba_state_type STATE_RESET = '{
    owner:            ID_NONE,
    last_owner:       ID_RESET_LAST,
    host_state:       MPBA_HOST_IDLE,
    dma_grant_first:  1'b0,
    dma_grant_second: 1'b0,
    dma_start_first:  1'b0,
    dma_start_second: 1'b0,
    owner_flag:       1'b0
  };

  // Line index for a processor code; codes outside 1..6 map to no line
  function automatic logic [PROC_COUNT-1:0] mpba_line_of(input logic [ID_WIDTH-1:0] code);
    logic [PROC_COUNT-1:0] mask;
    mask = '0;
    if (code >= ID_FIRST && code <= ID_LAST)
    begin
      mask[code - ID_FIRST] = 1'b1;
    end
    return mask;
  endfunction : mpba_line_of

endpackage : mpba_pkg

/* mpba_pick.sv */
// Priority picker: chooses the winning requester, fixed or rotating
`timescale 1ns/1ps
`default_nettype none
module mpba_pick
  import mpba_pkg::*;
(
  input  wire logic [PROC_COUNT-1:0] request,
  input  wire logic                  rotate,
  input  wire logic [ID_WIDTH-1:0]   last_owner,
  output logic      [ID_WIDTH-1:0]   winner
);

  logic [ID_WIDTH-1:0] start;
  logic [ID_WIDTH-1:0] slot;
  logic                found;

  always_comb
  begin
    winner = ID_NONE;
    found  = 1'b0;
    slot   = ID_NONE;
    // Rotating search starts just after the last owner's line
    if (rotate && last_owner >= ID_FIRST && last_owner < ID_LAST)
    begin
      start = last_owner;
    end
    else
    begin
      start = ID_NONE;
    end
    for (int unsigned k = 0; k < PROC_COUNT; k++)
    begin
      slot = ID_WIDTH'((int'(start) + k) % PROC_COUNT);
      if (!found && request[slot])
      begin
        winner = slot + ID_FIRST;
        found  = 1'b1;
      end
    end
  end

endmodule : mpba_pick
`default_nettype wire

/* mpba_arbiter.sv */
// Bus arbitration, DMA grant, priority access and host hand-off for one processor
`timescale 1ns/1ps
`default_nettype none
module mpba_arbiter
  import mpba_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic [ID_WIDTH-1:0]   processor_number,
  input  wire logic                  rotating_priority_select,
  // Shared request lines, active low
  input  wire logic [PROC_COUNT-1:0] bus_request_lines_n_in,
  output logic      [PROC_COUNT-1:0] bus_request_lines_n_out,
  output logic      [PROC_COUNT-1:0] bus_request_lines_n_oe,
  // Shared priority access line, active low
  input  wire logic                  priority_access_line_n_in,
  output logic                       priority_access_line_n_out,
  output logic                       priority_access_line_n_oe,
  // External DMA handshake, active low
  input  wire logic                  dma_request_first_n,
  input  wire logic                  dma_request_second_n,
  output logic                       dma_grant_first_n_out,
  output logic                       dma_grant_first_n_oe,
  output logic                       dma_grant_second_n_out,
  output logic                       dma_grant_second_n_oe,
  // Host bus hand-off, active low
  input  wire logic                  host_bus_request_n,
  output logic                       host_bus_grant_n_out,
  output logic                       host_bus_grant_n_oe,
  // Core side
  input  wire logic                  core_bus_request,
  input  wire logic                  core_priority_access,
  input  wire logic                  dma_channel_ready_first,
  input  wire logic                  dma_channel_ready_second,
  output logic                       dma_start_first,
  output logic                       dma_start_second,
  output logic                       bus_drive_enable,
  output logic                       bus_owner_flag
);

  mpba_state_type state_reg;
  mpba_state_type state_next;

  logic                  single_system;
  logic [PROC_COUNT-1:0] own_line;
  logic [PROC_COUNT-1:0] request_seen;
  logic [ID_WIDTH-1:0]   winner;
  logic                  is_owner;
  logic                  host_pending;
  logic                  access_seen;
  logic                  own_access;
  logic                  dma_want_first;
  logic                  dma_want_second;
  logic                  want_bus;
  logic                  owner_requests;
  logic                  host_active;
  logic                  dma_work;
  logic                  owner_yields;
  logic [ID_WIDTH-1:0]   rotate_from;

  // A lone processor never arbitrates and drives no request line
  assign single_system = (processor_number == ID_SINGLE);
  assign own_line      = mpba_line_of(processor_number);
  assign is_owner      = single_system || (state_reg.owner == processor_number);
  assign host_pending  = !host_bus_request_n;
  assign access_seen   = !priority_access_line_n_in;
  assign own_access    = core_priority_access && !is_owner;

  // Background DMA work keeps the bus only while no slave claims priority
  assign dma_want_first  = !dma_request_first_n && dma_channel_ready_first;
  assign dma_want_second = !dma_request_second_n && dma_channel_ready_second;
  assign dma_work = (dma_want_first || dma_want_second) && !(is_owner && access_seen);

  // A slave that won through priority access must keep asking, or it loses the bus at once
  assign want_bus = core_bus_request || core_priority_access || dma_work;

  // Every processor sees the same lines, so every copy of the owner tracks in step
  assign request_seen = ~bus_request_lines_n_in | (own_line & {PROC_COUNT{want_bus}});
  assign owner_requests = (state_reg.owner != ID_NONE)
                          && |(request_seen & mpba_line_of(state_reg.owner));
  assign host_active = (state_reg.host_state != MPBA_HOST_IDLE);

  // Owner gives way when it stops asking, or when a slave claims access and only DMA is left
  assign owner_yields = !owner_requests
                        || (access_seen && is_owner && !core_bus_request
                            && !core_priority_access);

  // Rotation demotes whoever holds the bus now; before any owner the reset seed is used,
  // so line one comes first after reset
  always_comb
  begin
    if (state_reg.owner != ID_NONE)
    begin
      rotate_from = state_reg.owner;
    end
    else
    begin
      rotate_from = state_reg.last_owner;
    end
  end

  mpba_pick u_pick (
    .request    (request_seen),
    .rotate     (rotating_priority_select),
    .last_owner (rotate_from),
    .winner     (winner)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.dma_start_first  = 1'b0;
    state_next.dma_start_second = 1'b0;
    state_next.dma_grant_first  = 1'b0;
    state_next.dma_grant_second = 1'b0;

    // Host request outranks every processor request; arbitration freezes
    unique case (state_reg.host_state)
      MPBA_HOST_IDLE:
      begin
        if (host_pending && is_owner)
        begin
          state_next.host_state = MPBA_HOST_RELEASE;
        end
      end
      MPBA_HOST_RELEASE:
      begin
        if (host_pending)
        begin
          state_next.host_state = MPBA_HOST_GRANT;
        end
        else
        begin
          state_next.host_state = MPBA_HOST_IDLE;
        end
      end
      MPBA_HOST_GRANT:
      begin
        if (!host_pending)
        begin
          state_next.host_state = MPBA_HOST_IDLE;
        end
      end
    endcase

    // Owner keeps the bus while it still requests, unless a slave claims access while the owner has only DMA work left
    if (!host_pending && !host_active && !single_system)
    begin
      if (owner_yields)
      begin
        state_next.owner = winner;
        if (state_reg.owner != ID_NONE)
        begin
          state_next.last_owner = state_reg.owner;
        end
      end
    end

    // A grant pulse means the transfer begins in the following cycle
    if (is_owner && !host_pending && !host_active && !access_seen && !state_reg.dma_grant_first
        && !state_reg.dma_grant_second)
    begin
      if (dma_want_first)
      begin
        state_next.dma_grant_first = 1'b1;
      end
      else if (dma_want_second)
      begin
        state_next.dma_grant_second = 1'b1;
      end
    end
    state_next.dma_start_first  = state_reg.dma_grant_first;
    state_next.dma_start_second = state_reg.dma_grant_second;

    // Except for number 000, flag falls as soon as a host request is seen, one cycle ahead of the grant
    state_next.owner_flag = single_system
                            || ((state_next.owner == processor_number)
                                && (state_next.host_state == MPBA_HOST_IDLE)
                                && !host_pending);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Only the own line is ever driven; the rest stay inputs
  assign bus_request_lines_n_oe  = single_system ? '0 : own_line;
  assign bus_request_lines_n_out = ~(own_line & {PROC_COUNT{want_bus}});

  // A master never claims priority access; it already holds the bus
  assign priority_access_line_n_oe  = own_access && !single_system;
  assign priority_access_line_n_out = 1'b0;

  // Grant pins are driven by the master alone
  assign dma_grant_first_n_oe   = state_reg.owner_flag;
  assign dma_grant_second_n_oe  = state_reg.owner_flag;
  // Between pulses the master keeps the grant lines driven high
  assign dma_grant_first_n_out  = !state_reg.dma_grant_first;
  assign dma_grant_second_n_out = !state_reg.dma_grant_second;

  // Grant floats during the release cycle, then is held low until the request ends
  assign host_bus_grant_n_oe  = (state_reg.host_state == MPBA_HOST_GRANT);
  assign host_bus_grant_n_out = 1'b0;
  // A lone processor stays owner under the host, yet still floats the bus for it
  assign bus_drive_enable     = state_reg.owner_flag
                                && (state_reg.host_state == MPBA_HOST_IDLE);

  assign dma_start_first  = state_reg.dma_start_first;
  assign dma_start_second = state_reg.dma_start_second;
  assign bus_owner_flag   = state_reg.owner_flag;

endmodule : mpba_arbiter
`default_nettype wire

/* mpba_monitor.sv */
// Port checker for the arbitration block
`timescale 1ns/1ps
`default_nettype none
module mpba_monitor (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [2:0] processor_number,
  input wire logic [5:0] bus_request_lines_n_out,
  input wire logic [5:0] bus_request_lines_n_oe,
  input wire logic       core_bus_request,
  input wire logic       bus_owner_flag,
  input wire logic       dma_grant_first_n_out,
  input wire logic       dma_grant_first_n_oe,
  input wire logic       dma_grant_second_n_out,
  input wire logic       dma_start_first,
  input wire logic       dma_request_first_n,
  input wire logic       dma_channel_ready_first,
  input wire logic       dma_request_second_n,
  input wire logic       dma_channel_ready_second,
  input wire logic       core_priority_access,
  input wire logic       priority_access_line_n_in,
  input wire logic       host_bus_request_n,
  input wire logic       host_bus_grant_n_oe
);
  logic [5:0] own_line;
  // Codes outside one to six own no line at all
  assign own_line = (processor_number inside {[3'h1:3'h6]}) ?
                    6'h01 << (processor_number - 3'h1) : 6'h00;
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  own_line_a: assert property (bus_request_lines_n_oe == own_line)
    else $error("wrong request line driven");
  req_level_a: assert property (
    core_bus_request |-> (~bus_request_lines_n_out & own_line) == own_line)
    else $error("own request level wrong");
  req_cause_a: assert property (
    (~bus_request_lines_n_out & own_line) != 6'h00 |-> core_bus_request || core_priority_access
    || (!dma_request_first_n && dma_channel_ready_first)
    || (!dma_request_second_n && dma_channel_ready_second))
    else $error("own request without cause");
  single_owner_a: assert property (processor_number == 3'h0 |=> bus_owner_flag)
    else $error("single system not owner");
  grant_master_a: assert property (!dma_grant_first_n_out |-> dma_grant_first_n_oe)
    else $error("grant driven by non-master");
  grant_start_a: assert property (
    !dma_grant_first_n_out |=> dma_start_first && dma_grant_first_n_out)
    else $error("transfer did not follow grant");
  grant_cause_a: assert property (
    !dma_grant_first_n_out |-> !$past(dma_request_first_n) && $past(dma_channel_ready_first))
    else $error("grant without request");
  pa_hold_a: assert property (
    !priority_access_line_n_in |=> dma_grant_first_n_out && dma_grant_second_n_out)
    else $error("grant during priority access");
  host_hand_a: assert property (
    !host_bus_request_n && bus_owner_flag && processor_number != 3'h0
    |=> !bus_owner_flag && !host_bus_grant_n_oe ##1 host_bus_grant_n_oe)
    else $error("host hand-off order wrong");
endmodule : mpba_monitor
bind mpba_arbiter mpba_monitor mpba_monitor_i (.*);
`default_nettype wire

/* mpba_peer_model.sv */
// Peers, port device and pull-ups on the shared lines
`timescale 1ns/1ps
`default_nettype none
module mpba_peer_model (
  input  wire logic [5:0] peer_want,
  input  wire logic       peer_pa,
  input  wire logic [1:0] port_want,
  input  wire logic [5:0] line_out,
  input  wire logic [5:0] line_oe,
  input  wire logic       pa_out,
  input  wire logic       pa_oe,
  output logic      [5:0] line_n,
  output logic            pa_n,
  output logic            dma1_n,
  output logic            dma2_n
);
  // Peers keep off the design's line; idle lines rest at the pull-up
  assign line_n = ~((peer_want & ~line_oe) | (line_oe & ~line_out));
  assign pa_n = ~(peer_pa | (pa_oe & ~pa_out));
  assign dma1_n = ~port_want[0];
  assign dma2_n = ~port_want[1];
endmodule : mpba_peer_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the arbitration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clock, reset_n, rotating_priority_select, core_bus_request;
  logic       core_priority_access, peer_pa, dma_request_first_n, dma_request_second_n;
  logic       host_bus_request_n, priority_access_line_n_in, dma_channel_ready_first;
  logic       dma_channel_ready_second, priority_access_line_n_out, priority_access_line_n_oe;
  logic       dma_grant_first_n_out, dma_grant_first_n_oe, dma_grant_second_n_out;
  logic       dma_grant_second_n_oe, host_bus_grant_n_out, host_bus_grant_n_oe;
  logic       dma_start_first, dma_start_second, bus_drive_enable, bus_owner_flag;
  logic [2:0] processor_number;
  logic [1:0] port_want;
  logic [5:0] bus_request_lines_n_in, bus_request_lines_n_out, bus_request_lines_n_oe, peer_want;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cycle_count = 0;

  mpba_arbiter mpba_arbiter_i (.*);
  mpba_peer_model mpba_peer_model_i (.peer_want(peer_want), .peer_pa(peer_pa),
    .port_want(port_want), .line_out(bus_request_lines_n_out),
    .line_oe(bus_request_lines_n_oe), .pa_out(priority_access_line_n_out),
    .pa_oe(priority_access_line_n_oe), .line_n(bus_request_lines_n_in),
    .pa_n(priority_access_line_n_in), .dma1_n(dma_request_first_n),
    .dma2_n(dma_request_second_n));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // Whole run needs at most about 120 cycles
  always @(posedge clock)
  begin
    cycle_count++;
    if (cycle_count == 2000)
    begin
      n_errors++;
      complete_run();
    end
  end

  // Reads right after an edge see the values of the cycle that edge closed
  task automatic check(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
      n_errors++;
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask : step

  task automatic restart(input logic [2:0] id, input logic rot);
    reset_n <= 1'b0;
    processor_number <= id;
    rotating_priority_select <= rot;
    {core_bus_request, core_priority_access, peer_pa, port_want, peer_want} <= '0;
    {dma_channel_ready_first, dma_channel_ready_second, host_bus_request_n} <= 3'h7;
    step(8);
    reset_n <= 1'b1;
    step(1);
  endtask : restart

  task automatic own_bus;
    restart(3'h3, 1'b0);
    core_bus_request <= 1'b1;
    step(3);
    check("owner", 1'b1, bus_owner_flag & bus_drive_enable);
  endtask : own_bus

  // Line 2 owns, lines 1 and 3 wait: fixed gives line 1, rotating line 3
  task automatic arb_order(input logic rot);
    restart(3'h3, rot);
    peer_want <= 6'h02;
    step(3);
    core_bus_request <= 1'b1;
    peer_want <= 6'h03;
    step(3);
    check("line", 1'b1, bus_request_lines_n_oe === 6'h04 && !bus_request_lines_n_in[2]);
    check("owner", 1'b0, bus_owner_flag);
    peer_want <= 6'h01;
    step(4);
    check("owner", rot, bus_owner_flag);
  endtask : arb_order

  task automatic dma_order;
    int k;
    own_bus();
    port_want <= 2'h3;
    for (k = 0; k < 8 && dma_grant_first_n_out !== 1'b0; k++) step(1);
    check("grant1", 1'b0, dma_grant_first_n_out);
    check("grant2", 1'b1, dma_grant_second_n_out);
    port_want <= 2'h2;
    step(1);
    check("start1", 1'b1, dma_start_first);
    for (k = 0; k < 8 && dma_grant_second_n_out !== 1'b0; k++) step(1);
    check("grant2", 1'b0, dma_grant_second_n_out);
  endtask : dma_order

  task automatic pa_preempt;
    own_bus();
    port_want <= 2'h1;
    peer_pa <= 1'b1;
    step(4);
    check("grant1", 1'b1, dma_grant_first_n_out);
    core_bus_request <= 1'b0;
    peer_want <= 6'h01;
    step(3);
    check("owner", 1'b0, bus_owner_flag);
    core_priority_access <= 1'b1;
    peer_pa <= 1'b0;
    step(2);
    check("pa", 1'b1, priority_access_line_n_oe && !priority_access_line_n_in);
    peer_want <= 6'h00;
    step(3);
    check("owner", 1'b1, bus_owner_flag);
  endtask : pa_preempt

  task automatic host_handoff;
    own_bus();
    host_bus_request_n <= 1'b0;
    step(2);
    check("owner", 1'b0, bus_owner_flag | bus_drive_enable | host_bus_grant_n_oe);
    step(1);
    check("hostgrant", 1'b1, host_bus_grant_n_oe && !host_bus_grant_n_out);
    host_bus_request_n <= 1'b1;
    step(2);
    check("hostgrant", 1'b0, host_bus_grant_n_oe);
    check("owner", 1'b1, bus_owner_flag);
  endtask : host_handoff

  initial
  begin
    arb_order(1'b0);
    arb_order(1'b1);
    dma_order();
    pa_preempt();
    host_handoff();
    restart(3'h0, 1'b0);
    step(1);
    check("owner", 1'b1, bus_owner_flag);
    check("line", 1'b1, bus_request_lines_n_oe === 6'h00);
    host_bus_request_n <= 1'b0;
    step(3);
    check("drive", 1'b0, bus_drive_enable);
    check("owner", 1'b1, bus_owner_flag);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
